// *** common/flash_burst_pkg.sv ***
package flash_burst_pkg;
    // ==========================================================
    // widths
    localparam int CFG_W = 16;
    localparam int DQ_W = 32;
    localparam int ADDR_W = 20;
    localparam int FIFO_DEPTH = 16;
    // ==========================================================
    // burst read configuration register layout
    localparam logic [15:0] CFG_RESET = 16'h9cc3;
    localparam logic [15:0] CFG_RSVD_MASK = 16'h4038;
    localparam int RM_BIT = 15;
    localparam int LAT_LSB = 10;
    localparam int LAT_W = 4;
    localparam int HOLD_BIT = 9;
    localparam int IND_BIT = 8;
    localparam int ORDER_BIT = 7;
    localparam int EDGE_BIT = 6;
    localparam int BL_LSB = 0;
    localparam int BL_W = 3;
    // ==========================================================
    // codes and timing
    localparam logic [3:0] LAT_BASE = 4'h2;
    localparam logic [2:0] BL_8B = 3'h1;
    localparam logic [2:0] BL_16B = 3'h2;
    localparam logic [2:0] BL_32B = 3'h3;
    localparam logic [3:0] WORDS_8B = 4'h2;
    localparam logic [3:0] WORDS_16B = 4'h4;
    localparam logic [3:0] WORDS_32B = 4'h8;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_DATA = 3'b100
    } burst_state_e;
endpackage

// *** rtl/burst_word_fifo.sv ***
`timescale 1ns/1ps
module burst_word_fifo #(
    parameter int W = 32,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } fifo_s;

    fifo_s s;
    fifo_s next_s;
    logic push;
    logic pop;

    assign in_ready = (s.cnt != (AW+1)'(DEPTH));
    assign out_valid = (s.cnt != '0);
    assign out_data = s.mem[s.rd];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        next_s = s;
        if (flush) begin
            // flush beats a same-cycle push from an abandoned burst
            next_s.wr = '0;
            next_s.rd = '0;
            next_s.cnt = '0;
        end else begin
            if (push) begin
                next_s.mem[s.wr] = in_data;
                next_s.wr = s.wr + 1'b1;
            end
            if (pop) begin
                next_s.rd = s.rd + 1'b1;
            end
            next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule

// *** rtl/flash_burst_read_config.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// R1 - latency applies only to synchronous burst reads, never to asynchronous reads
// R2 - latency counted in clocks from the burst start edge to first data edge
// R3 - burst starts and address latched at first clock with strobe low
// R4 - latency code 0..7 gives 2..9 clocks; default code 0111
// R5 - data launched on rising clock edges; edge bit defaults to 1
// R6 - each burst word held exactly one clock; hold bit defaults to 0
// R7 - reset low aborts the burst and restores asynchronous mode
// R8 - register has no address; reached only by read and write commands
// R9 - configuration write during program or erase is discarded
// R10 - register readable at any time, even during program or erase
// R11 - register on lower 16 lanes; upper lanes read zero
// R12 - read command latches bank; that bank shows register, other bank array
// R13 - read mode bit 0 selects burst reads, 1 asynchronous (default)
// R14 - host writes zero to bits 14 and 5 to 3
// R15 - indicator timing bit selects last or second-to-last transfer
// R16 - burst order bit 1 means linear order, the default
// R17 - length codes 1,2,3 give 2,4,8 words; others disable bursts
// R18 - reset value holds async mode, latency 0111, linear, rising edge
// R19 - host picks latency code to suit its clock rate
// R20 - register reads are single-cycle and stay valid while output enabled
// R21 - indicator marks last transfer before wrap; further clocks wrap around
// R22 - chip enable high leaves the burst at once and floats the bus
// R23 - output enable high floats the bus, burst keeps advancing
// R24 - burst length resets to 011
module flash_burst_read_config
    import flash_burst_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE_N,
    input wire logic OE_N,
    input wire logic ADDR_VALID_STROBE_N,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic BANK_SEL,
    input wire logic CFG_RD_CMD,
    input wire logic CFG_WR_CMD,
    input wire logic CFG_EXIT_CMD,
    input wire logic [CFG_W-1:0] CFG_WDATA,
    input wire logic ALGO_BUSY,
    output logic [ADDR_W-1:0] ARRAY_ADDR,
    input wire logic [DQ_W-1:0] ARRAY_RDATA,
    output logic [DQ_W-1:0] DATA_OUT,
    output logic DATA_OE,
    output logic BURST_END_INDICATOR_N,
    output logic BURST_END_INDICATOR_OE,
    output logic [CFG_W-1:0] CFG_VALUE
);
    // ==========================================================
    // state
    typedef struct packed {
        burst_state_e st;
        logic [CFG_W-1:0] cfg;
        logic reg_view;
        logic reg_bank;
        logic adv_prev;
        logic [LAT_W-1:0] lat;
        logic [ADDR_W-1:0] base;
        logic [2:0] fetch_k;
        logic [2:0] beat;
        logic [DQ_W-1:0] dq;
        logic dq_oe;
        logic ind_n;
        logic ind_oe;
    } state_s;

    state_s s;
    state_s next_s;

    // ==========================================================
    // helpers
    function automatic logic [3:0] burst_words(input logic [BL_W-1:0] bl);
        logic [3:0] n;
        n = 4'h0;
        unique case (bl)
            BL_8B: n = WORDS_8B; // R17
            BL_16B: n = WORDS_16B;
            BL_32B: n = WORDS_32B;
            default: n = 4'h0;
        endcase
        return n;
    endfunction

    // linear order inside an aligned block of n words
    function automatic logic [ADDR_W-1:0] wrap_addr(
        input logic [ADDR_W-1:0] base,
        input logic [2:0] k,
        input logic [3:0] n
    );
        logic [2:0] m;
        logic [2:0] low;
        m = 3'(n - 4'h1);
        low = base[2:0] + k;
        return {base[ADDR_W-1:3], (base[2:0] & ~m) | (low & m)}; // R16 R21
    endfunction

    function automatic logic [2:0] step(input logic [2:0] k, input logic [3:0] n);
        return (4'(k) == n - 4'h1) ? 3'h0 : 3'(k + 3'h1); // R21
    endfunction

    // ==========================================================
    // decode
    logic [3:0] words;
    logic sync_mode;
    logic reg_hit;
    logic start;
    logic [2:0] last_idx;
    logic push_valid;
    logic push_ready;
    logic pop_ready;
    logic pop_valid;
    logic [DQ_W-1:0] pop_data;
    logic flush;
    logic fire;

    assign words = burst_words(s.cfg[BL_LSB +: BL_W]);
    assign sync_mode = !s.cfg[RM_BIT] && (words != 4'h0); // R13 R17
    assign reg_hit = s.reg_view && (BANK_SEL == s.reg_bank); // R12
    // first rising clock seeing the strobe low; a strobe that rises first
    // has already been seen low at an edge in this synchronous model
    assign start = !ADDR_VALID_STROBE_N && s.adv_prev && !CE_N
        && sync_mode && !reg_hit; // R3 R20
    // indicator one beat early when timing bit is set
    assign last_idx = 3'(words - 4'h1) - 3'(s.cfg[IND_BIT]); // R15
    assign flush = start || CE_N; // R22
    assign push_valid = (s.st != ST_IDLE) && !CE_N;
    assign pop_ready = (s.st == ST_DATA) || ((s.st == ST_WAIT) && (s.lat == '0));
    assign fire = pop_ready && pop_valid && !flush;
    assign ARRAY_ADDR = (s.st != ST_IDLE) ? wrap_addr(s.base, s.fetch_k, words) : ADDR;

    assign DATA_OUT = s.dq;
    assign DATA_OE = s.dq_oe;
    assign BURST_END_INDICATOR_N = s.ind_n;
    assign BURST_END_INDICATOR_OE = s.ind_oe;
    assign CFG_VALUE = s.cfg;

    // ==========================================================
    // word buffer between array fetch and burst output
    burst_word_fifo #(
        .W(DQ_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(CLK),
        .rst_n(RST_N),
        .flush(flush),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data(ARRAY_RDATA),
        .out_valid(pop_valid),
        .out_ready(pop_ready),
        .out_data(pop_data)
    );

    // ==========================================================
    // next state
    always_comb begin
        next_s = s;
        next_s.adv_prev = ADDR_VALID_STROBE_N;

        // command port
        if (CFG_RD_CMD) begin
            next_s.reg_view = 1'b1; // R8 R12
            next_s.reg_bank = BANK_SEL;
        end else if (CFG_EXIT_CMD) begin
            next_s.reg_view = 1'b0;
        end
        if (CFG_WR_CMD && !ALGO_BUSY) begin
            // reserved bits kept at zero whatever the host sends
            next_s.cfg = CFG_WDATA & ~CFG_RSVD_MASK; // R8 R9 R14
        end

        // array fetch runs ahead, stalled by a full buffer
        if (push_valid && push_ready) begin
            next_s.fetch_k = step(s.fetch_k, words);
        end

        unique case (s.st)
            ST_IDLE: begin
                // asynchronous path, no latency
                next_s.dq = reg_hit ? {16'h0000, s.cfg} : ARRAY_RDATA; // R1 R10 R11
                next_s.dq_oe = !CE_N && !OE_N; // R20
                next_s.ind_oe = 1'b0;
                next_s.ind_n = 1'b1;
            end
            ST_WAIT: begin
                if (s.lat != '0) begin
                    next_s.lat = s.lat - 1'b1; // R2
                end else if (fire) begin
                    next_s.st = ST_DATA;
                end
                next_s.dq_oe = 1'b0;
                next_s.ind_oe = !CE_N && !OE_N;
                next_s.ind_n = 1'b1;
            end
            ST_DATA: begin
                next_s.dq_oe = !CE_N && !OE_N; // R23
                next_s.ind_oe = !CE_N && !OE_N;
            end
            default: begin
                next_s.st = ST_IDLE;
            end
        endcase

        // each popped word stands on the bus for one clock only
        if (fire) begin
            next_s.dq = pop_data; // R5 R6
            next_s.beat = step(s.beat, words);
            next_s.ind_n = (s.beat != last_idx); // R15 R21
            next_s.dq_oe = !CE_N && !OE_N; // R23
        end else if (s.st == ST_DATA) begin
            next_s.ind_n = 1'b1;
        end

        if (start) begin
            next_s.st = ST_WAIT;
            next_s.base = ADDR; // R3
            next_s.fetch_k = 3'h0;
            next_s.beat = 3'h0;
            next_s.lat = s.cfg[LAT_LSB +: LAT_W] + LAT_BASE - 4'h2 + 4'h1; // R2 R4
            next_s.dq_oe = 1'b0;
            next_s.ind_n = 1'b1;
        end else if (CE_N) begin
            next_s.st = ST_IDLE; // R22
            next_s.dq_oe = 1'b0;
            next_s.ind_oe = 1'b0;
            next_s.ind_n = 1'b1;
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            s <= '0;
            s.st <= ST_IDLE; // R7
            s.cfg <= CFG_RESET; // R7 R18 R24
            s.adv_prev <= 1'b1;
            s.ind_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end
endmodule

// *** verif/flash_array_model.sv ***
`timescale 1ns/1ps
// ==========================================================
// array stand-in: the word is a pure function of its address,
// so every burst beat shows which address was fetched
module flash_array_model
    import flash_burst_pkg::*;
(
    input wire logic [ADDR_W-1:0] addr,
    output logic [DQ_W-1:0] rdata
);
    assign rdata = {12'h5a5, addr};
endmodule

// *** verif/flash_burst_read_config_asserts.sv ***
`timescale 1ns/1ps
module flash_burst_read_config_asserts
    import flash_burst_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE_N,
    input wire logic OE_N,
    input wire logic CFG_WR_CMD,
    input wire logic [CFG_W-1:0] CFG_WDATA,
    input wire logic ALGO_BUSY,
    input wire logic DATA_OE,
    input wire logic BURST_END_INDICATOR_N,
    input wire logic BURST_END_INDICATOR_OE,
    input wire logic [CFG_W-1:0] CFG_VALUE
);
    default clocking cb @(posedge CLK);
    endclocking
    // ==========================================================
    // reset checks run without a disable, they watch reset itself
    a_reset_cfg_default: assert property (!RST_N |=> CFG_VALUE == 16'h9cc3)
        else $error("config not at default after reset");
    a_reset_floats_bus: assert property (!RST_N |=> !DATA_OE && !BURST_END_INDICATOR_OE)
        else $error("bus driven after reset");
    a_ce_floats_bus: assert property (disable iff (!RST_N) CE_N |=> !DATA_OE)
        else $error("bus driven with chip disabled");
    a_oe_floats_bus: assert property (disable iff (!RST_N) OE_N |=> !DATA_OE)
        else $error("bus driven with output disabled");
    a_busy_write_dropped: assert property (disable iff (!RST_N)
        CFG_WR_CMD && ALGO_BUSY |=> $stable(CFG_VALUE))
        else $error("config changed during busy write");
    a_write_takes_masked: assert property (disable iff (!RST_N) CFG_WR_CMD && !ALGO_BUSY
        |=> CFG_VALUE == ($past(CFG_WDATA) & ~CFG_RSVD_MASK))
        else $error("config write not stored");
    a_ind_single_cycle: assert property (disable iff (!RST_N)
        $fell(BURST_END_INDICATOR_N) |=> BURST_END_INDICATOR_N)
        else $error("indicator low longer than one clock");
    a_async_one_cycle: assert property (disable iff (!RST_N)
        CFG_VALUE[RM_BIT] && !CE_N && !OE_N |=> DATA_OE)
        else $error("asynchronous read not driven next clock");
endmodule
bind flash_burst_read_config flash_burst_read_config_asserts chk (.CLK(CLK), .RST_N(RST_N), .CE_N(CE_N),
    .OE_N(OE_N), .CFG_WR_CMD(CFG_WR_CMD), .CFG_WDATA(CFG_WDATA), .ALGO_BUSY(ALGO_BUSY), .DATA_OE(DATA_OE),
    .BURST_END_INDICATOR_N(BURST_END_INDICATOR_N), .BURST_END_INDICATOR_OE(BURST_END_INDICATOR_OE),
    .CFG_VALUE(CFG_VALUE));

// *** verif/flash_burst_read_config_tb_top.sv ***
`timescale 1ns/1ps
module flash_burst_read_config_tb_top
    import flash_burst_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0, ce_n = 1'b1, oe_n = 1'b1, stb_n = 1'b1, bank = 1'b0;
    logic rd_cmd = 1'b0, wr_cmd = 1'b0, exit_cmd = 1'b0, busy = 1'b0;
    logic [ADDR_W-1:0] addr = '0, array_addr;
    logic [CFG_W-1:0] wdata = '0, cfg;
    logic [DQ_W-1:0] rdata, dout;
    logic doe, ind_n, ind_oe;
    int fails = 0, n_tests = 0;
    always #5 clk = ~clk;
    flash_burst_read_config uut (.CLK(clk), .RST_N(rst_n), .CE_N(ce_n), .OE_N(oe_n), .ADDR_VALID_STROBE_N(stb_n),
        .ADDR(addr), .BANK_SEL(bank), .CFG_RD_CMD(rd_cmd), .CFG_WR_CMD(wr_cmd), .CFG_EXIT_CMD(exit_cmd),
        .CFG_WDATA(wdata), .ALGO_BUSY(busy), .ARRAY_ADDR(array_addr), .ARRAY_RDATA(rdata), .DATA_OUT(dout),
        .DATA_OE(doe), .BURST_END_INDICATOR_N(ind_n), .BURST_END_INDICATOR_OE(ind_oe), .CFG_VALUE(cfg));
    flash_array_model mem (.addr(array_addr), .rdata(rdata));
    // ==========================================================
    // helpers
    function automatic logic [DQ_W-1:0] word_at(input logic [ADDR_W-1:0] a);
        return {12'h5a5, a};
    endfunction
    task automatic chk(input logic [DQ_W-1:0] got, input logic [DQ_W-1:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        if (fails == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // extra clock so the check never races the register update
    task automatic cfg_write(input logic [CFG_W-1:0] v);
        @(negedge clk);
        wr_cmd = 1'b1;
        wdata = v;
        @(negedge clk);
        wr_cmd = 1'b0;
        @(negedge clk);
    endtask
    // ==========================================================
    // scenarios
    task automatic t_cfg_access;
        busy = 1'b1;
        cfg_write(16'h0001);
        chk(32'(cfg), 32'h00001c40);
        rd_cmd = 1'b1;
        bank = 1'b1;
        @(negedge clk);
        rd_cmd = 1'b0;
        ce_n = 1'b0;
        oe_n = 1'b0;
        addr = 20'h00042;
        repeat (4) @(negedge clk);
        chk(dout, 32'h00001c40);
        bank = 1'b0;
        @(negedge clk);
        chk(dout, word_at(addr));
        busy = 1'b0;
        cfg_write(16'hffff);
        chk(32'(cfg), 32'h0000bfc7);
        exit_cmd = 1'b1;
        @(negedge clk);
        exit_cmd = 1'b0;
        ce_n = 1'b1;
    endtask
    // reads with bursts off must answer one clock after the strobe
    task automatic t_async(input logic [CFG_W-1:0] v);
        cfg_write(v);
        ce_n = 1'b0;
        oe_n = 1'b0;
        addr = 20'h00123;
        stb_n = 1'b0;
        @(negedge clk);
        stb_n = 1'b1;
        chk(dout, word_at(addr));
        ce_n = 1'b1;
    endtask
    task automatic t_burst(input logic [ADDR_W-1:0] base, input int lat, input int bl, input int wc, input bit gap);
        int n;
        logic [ADDR_W-1:0] blk;
        n = 1 << bl;
        blk = base & ~ADDR_W'(n - 1);
        cfg_write(CFG_W'(16'h00c0 | (lat << 10) | (wc << 8) | bl));
        ce_n = 1'b0;
        oe_n = 1'b0;
        addr = base;
        stb_n = 1'b0;
        @(negedge clk);
        stb_n = 1'b1;
        // first word is registered at the edge code+2 after the start edge
        repeat (lat + 2) @(negedge clk);
        for (int k = 0; k <= n; k++) begin
            if (gap && k == 1) begin
                chk(32'({ind_oe, doe}), 32'h0);
                oe_n = 1'b0;
            end else begin
                chk(dout, word_at(blk | ADDR_W'((base + k) & (n - 1))));
                chk(32'({ind_oe, ind_n}), 32'({1'b1, k % n != n - 1 - wc}));
            end
            if (gap && k == 0)
                oe_n = 1'b1;
            @(negedge clk);
        end
        ce_n = 1'b1;
        @(negedge clk);
        chk(32'(doe), 32'h0);
    endtask
    task automatic t_reset_mid;
        cfg_write(16'h00c3);
        ce_n = 1'b0;
        oe_n = 1'b0;
        stb_n = 1'b0;
        @(negedge clk);
        stb_n = 1'b1;
        rst_n = 1'b0;
        @(negedge clk);
        rst_n = 1'b1;
        chk({cfg, 15'h0, doe}, 32'h9cc30000);
        // aborted burst leaves plain asynchronous reads behind
        @(negedge clk);
        chk(dout, word_at(addr));
        ce_n = 1'b1;
    endtask
    initial begin
        #300000;
        fails++;
        tally_and_finish();
    end
    initial begin
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        chk({cfg, 14'h0, ind_oe, doe}, 32'h9cc30000);
        t_async(16'h9cc3);
        t_async(16'h1c44);
        t_async(16'h1c40);
        t_cfg_access();
        for (int bl = 1; bl <= 3; bl++)
            for (int wc = 0; wc <= 1; wc++)
                t_burst(ADDR_W'(16 + bl * 5 + wc), bl * 2 + wc - 2, bl, wc, 1'b0);
        t_burst(20'h00035, 7, 3, 0, 1'b1);
        t_reset_mid();
        tally_and_finish();
    end
endmodule
